// [design/gpc_pkg.sv]
// Shared constants and types for the eight-pin general purpose control port.
package gpc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W           = 12;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned STRB_W           = 4;
  localparam logic [11:0] GPC_CTRL_OFFSET  = 12'hB8;

  // ---------------------------------------------------------------------------
  // Field layout of one pin group
  // ---------------------------------------------------------------------------
  localparam int unsigned PIN_COUNT        = 8;
  localparam int unsigned GROUP_W          = 4;
  localparam int unsigned IN_POS           = 0;
  localparam int unsigned OE_POS           = 1;
  localparam int unsigned VAL_POS          = 2;
  localparam int unsigned RSV_POS          = 3;
  localparam int unsigned PINS_PER_BYTE    = 2;
  localparam logic [31:0] RSV_MASK         = 32'h8888_8888;

  // ---------------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------------
  localparam logic        OE_RST           = 1'b0;
  localparam logic        VAL_RST          = 1'b0;
  localparam logic        SYNC_RST         = 1'b0;
  localparam logic [31:0] RDATA_RST        = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Cycle counts
  // ---------------------------------------------------------------------------
  localparam int unsigned SYNC_STAGES      = 2;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RESP
  } gpc_apb_state_type;

endpackage : gpc_pkg

// [design/gpc_pin_cell.sv]
// One general purpose pin: input synchroniser, direction and output value bits.
module gpc_pin_cell
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // Register write side
  input  wire logic wr_en_in,
  input  wire logic oe_data_in,
  input  wire logic val_data_in,
  // Pin side
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe_out,
  // Register read side
  output logic      sampled_out,
  output logic      oe_out,
  output logic      val_out
);

  logic sync1_reg;
  logic sync2_reg;
  logic oe_reg;
  logic val_reg;

  // ---------------------------------------------------------------------------
  // Input sampling
  // ---------------------------------------------------------------------------
  // The first stage is read only by the second, so a metastable pin level never reaches the bus.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      sync1_reg <= gpc_pkg::SYNC_RST;
      sync2_reg <= gpc_pkg::SYNC_RST;
    end
    else
    begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Direction and output value
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      oe_reg  <= gpc_pkg::OE_RST;
      val_reg <= gpc_pkg::VAL_RST;
    end
    else if (wr_en_in)
    begin
      oe_reg  <= oe_data_in;
      val_reg <= val_data_in;
    end
  end

  assign sampled_out = sync2_reg;
  assign oe_out      = oe_reg;
  assign val_out     = val_reg;
  assign pad_oe_out  = oe_reg;
  assign pad_out     = val_reg;

endmodule : gpc_pin_cell

// [design/gpc_gpio_ctrl.sv]
// APB-reached eight-pin general purpose control register with its pin logic.
module gpc_gpio_ctrl
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Port role strap, high on the upstream port
  input  wire logic        upstream_strap_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  // General purpose pins
  input  wire logic [7:0]  gpio_pin_in,
  output logic [7:0]       gpio_pin_out,
  output logic [7:0]       gpio_pin_oe_out,
  // Status
  output logic             upstream_role_out
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  gpc_pkg::gpc_apb_state_type state_reg;
  gpc_pkg::gpc_apb_state_type state_next;

  logic        strap_sync1_reg;
  logic        strap_sync2_reg;
  logic        role_up_reg;
  logic        role_valid_reg;
  logic [31:0] prdata_reg;
  logic        err_reg;
  logic        addr_hit;
  logic        access_ok;
  logic        commit;
  logic [31:0] read_word;
  logic [7:0]  in_bits;
  logic [7:0]  oe_bits;
  logic [7:0]  val_bits;
  logic [7:0]  wr_en_bits;
  logic [7:0]  wr_oe_bits;
  logic [7:0]  wr_val_bits;

  // ---------------------------------------------------------------------------
  // Port role
  // ---------------------------------------------------------------------------
  // The strap is a pin, so it is synchronised and then caught once after reset.
  // The synchroniser runs through reset, so both stages already hold the strap when it is caught.
  always_ff @(posedge clk_sys_in)
  begin
    strap_sync1_reg <= upstream_strap_in;
    strap_sync2_reg <= strap_sync1_reg;
  end

  // The role is caught on the second cycle after release, when the strap has cleared both stages.
  logic capture_wait_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      capture_wait_reg <= 1'b1;
      role_valid_reg   <= 1'b0;
      role_up_reg      <= 1'b0;
    end
    else if (!role_valid_reg)
    begin
      capture_wait_reg <= 1'b0;
      if (!capture_wait_reg)
      begin
        role_valid_reg <= 1'b1;
        role_up_reg    <= strap_sync2_reg;
      end
    end
  end

  assign upstream_role_out = role_up_reg;

  // ---------------------------------------------------------------------------
  // APB access control
  // ---------------------------------------------------------------------------
  assign addr_hit  = (paddr_in[11:2] == gpc_pkg::GPC_CTRL_OFFSET[11:2]);
  assign access_ok = addr_hit && role_up_reg;

  // The answer waits one cycle in the access phase, and also until the role is known.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      gpc_pkg::ST_IDLE:
      begin
        if (psel_in && penable_in && role_valid_reg)
        begin
          state_next = gpc_pkg::ST_RESP;
        end
      end
      gpc_pkg::ST_RESP:
      begin
        state_next = gpc_pkg::ST_IDLE;
      end
      default:
      begin
        state_next = gpc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_reg <= gpc_pkg::ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      prdata_reg <= gpc_pkg::RDATA_RST;
      err_reg    <= 1'b0;
    end
    else if (state_reg == gpc_pkg::ST_IDLE && psel_in && penable_in && role_valid_reg)
    begin
      prdata_reg <= (access_ok && !pwrite_in) ? read_word : gpc_pkg::RDATA_RST;
      err_reg    <= !access_ok;
    end
  end

  assign pready_out  = (state_reg == gpc_pkg::ST_RESP);
  assign pslverr_out = (state_reg == gpc_pkg::ST_RESP) && err_reg;
  assign prdata_out  = prdata_reg;
  assign commit      = pready_out && psel_in && penable_in && pwrite_in && access_ok;

  // ---------------------------------------------------------------------------
  // Register layout
  // ---------------------------------------------------------------------------
  always_comb
  begin
    read_word = 32'h0000_0000;
    for (int n = 0; n < gpc_pkg::PIN_COUNT; n++)
    begin
      read_word[gpc_pkg::GROUP_W * n + gpc_pkg::IN_POS]  = in_bits[n];
      read_word[gpc_pkg::GROUP_W * n + gpc_pkg::OE_POS]  = oe_bits[n];
      read_word[gpc_pkg::GROUP_W * n + gpc_pkg::VAL_POS] = val_bits[n];
    end
  end

  // Input and reserved bits of the write data are simply never picked up.
  always_comb
  begin
    wr_en_bits  = 8'h00;
    wr_oe_bits  = 8'h00;
    wr_val_bits = 8'h00;
    for (int n = 0; n < gpc_pkg::PIN_COUNT; n++)
    begin
      wr_en_bits[n]  = commit && pstrb_in[n / gpc_pkg::PINS_PER_BYTE];
      wr_oe_bits[n]  = pwdata_in[gpc_pkg::GROUP_W * n + gpc_pkg::OE_POS];
      wr_val_bits[n] = pwdata_in[gpc_pkg::GROUP_W * n + gpc_pkg::VAL_POS];
    end
  end

  // ---------------------------------------------------------------------------
  // Pin cells
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < 8; g++)
  begin : g_pin
    gpc_pin_cell u_cell
    (
      .clk_sys_in  (clk_sys_in),
      .rst_in      (rst_in),
      .wr_en_in    (wr_en_bits[g]),
      .oe_data_in  (wr_oe_bits[g]),
      .val_data_in (wr_val_bits[g]),
      .pad_in      (gpio_pin_in[g]),
      .pad_out     (gpio_pin_out[g]),
      .pad_oe_out  (gpio_pin_oe_out[g]),
      .sampled_out (in_bits[g]),
      .oe_out      (oe_bits[g]),
      .val_out     (val_bits[g])
    );
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  reset_clears_a: assert property (
    $past(rst_in) |-> (oe_bits == 8'h00) && (val_bits == 8'h00) && (gpio_pin_oe_out == 8'h00))
    else $error("Enables or values not clear after reset.");

  input_follows_a: assert property (
    (!$past(rst_in) && !$past(rst_in, 2)) |-> (in_bits == $past(gpio_pin_in, 2)))
    else $error("Input bits do not follow the pins two cycles later.");

  direction_drive_a: assert property (
    (gpio_pin_oe_out == oe_bits) && ((gpio_pin_out & gpio_pin_oe_out) == (val_bits & oe_bits)))
    else $error("Pin drive does not match enable and value bits.");

  write_lands_a: assert property (
    (commit && pstrb_in == 4'hF) |=> (oe_bits == $past(wr_oe_bits)) && (val_bits == $past(wr_val_bits)))
    else $error("Full write did not update enables and values.");

  read_layout_a: assert property (
    (psel_in && penable_in && !pwrite_in && access_ok && state_reg == gpc_pkg::ST_IDLE && role_valid_reg)
      |=> pready_out && (prdata_out[1] == oe_bits[0]) && (prdata_out[26] == val_bits[6])
          && (prdata_out[25] == oe_bits[6]) && (prdata_out[28] == $past(in_bits[7])))
    else $error("Read word layout is wrong.");

  reserved_zero_a: assert property (
    pready_out |-> ((prdata_out & gpc_pkg::RSV_MASK) == 32'h0000_0000))
    else $error("Reserved bits read non-zero.");

  downstream_absent_a: assert property (
    (pready_out && !role_up_reg) |-> pslverr_out ##1 $stable(oe_bits) && $stable(val_bits))
    else $error("Downstream port answered the control register.");

  answer_bound_a: assert property (
    (psel_in && penable_in && role_valid_reg && !pready_out) |=> pready_out)
    else $error("Access was not answered within one cycle.");

  ready_one_cycle_a: assert property (
    pready_out |=> !pready_out)
    else $error("Ready stood for more than one cycle.");

  role_held_a: assert property (
    role_valid_reg |=> role_valid_reg && $stable(role_up_reg))
    else $error("Captured port role changed outside reset.");

  role_capture_a: assert property (
    $rose(role_valid_reg) |-> (upstream_role_out == $past(strap_sync2_reg)))
    else $error("Port role was not taken from the synchronised strap.");

  role_wait_a: assert property (
    !role_valid_reg |-> !pready_out)
    else $error("Access answered before the port role was known.");

  access_err_a: assert property (
    (pready_out && role_up_reg) |-> (pslverr_out == !$past(addr_hit)))
    else $error("Error response does not match the address decode.");

  err_read_zero_a: assert property (
    (pready_out && pslverr_out) |-> (prdata_out == 32'h0000_0000))
    else $error("Refused access returned non-zero read data.");

  write_data_zero_a: assert property (
    (pready_out && pwrite_in) |-> (prdata_out == 32'h0000_0000))
    else $error("Write access left non-zero read data.");

  prdata_holds_a: assert property (
    !(state_reg == gpc_pkg::ST_IDLE && psel_in && penable_in && role_valid_reg) |=> $stable(prdata_out))
    else $error("Read data changed without a new access.");

  reset_state_a: assert property (
    $past(rst_in) |-> !role_valid_reg && !pready_out && !upstream_role_out && (prdata_out == 32'h0000_0000))
    else $error("Bus side not idle after reset.");

  write_only_a: assert property (
    ($changed(oe_bits) || $changed(val_bits)) |-> $past(commit))
    else $error("Enable or value bits changed without a write.");

  pins_follow_write_a: assert property (
    !commit |=> $stable(gpio_pin_oe_out) && $stable(gpio_pin_out))
    else $error("Pin drive changed without a write.");

  write_fields_a: assert property (
    (commit && pstrb_in == 4'hF)
      |=> (oe_bits[0] == $past(pwdata_in[1])) && (val_bits[0] == $past(pwdata_in[2]))
          && (oe_bits[6] == $past(pwdata_in[25])) && (val_bits[7] == $past(pwdata_in[30])))
    else $error("Write fields land on the wrong pins.");

  read_inputs_a: assert property (
    (psel_in && penable_in && !pwrite_in && access_ok && state_reg == gpc_pkg::ST_IDLE && role_valid_reg)
      |=> {prdata_out[28], prdata_out[24], prdata_out[20], prdata_out[16],
           prdata_out[12], prdata_out[8], prdata_out[4], prdata_out[0]} == $past(in_bits))
    else $error("Read word does not carry the sampled pin levels.");

  // Pins whose byte strobe is set in the current access.
  logic [7:0] strb_pins;

  assign strb_pins = {{2{pstrb_in[3]}}, {2{pstrb_in[2]}}, {2{pstrb_in[1]}}, {2{pstrb_in[0]}}};

  strobe_gate_a: assert property (
    commit |=> (((oe_bits ^ $past(oe_bits)) | (val_bits ^ $past(val_bits))) & ~$past(strb_pins)) == 8'h00)
    else $error("A pin outside the byte strobes changed on a write.");

endmodule : gpc_gpio_ctrl

// [tb/gpc_board_model.sv]
// Board-side model of the eight general purpose pins.
module gpc_board_model
(
  // Board intent
  input  wire logic [7:0] board_level_in,
  // Device drivers
  input  wire logic [7:0] pin_val_in,
  input  wire logic [7:0] pin_oe_in,
  // Resolved pin levels
  output logic [7:0]      pin_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------------------
  // The board drives through series resistors, so an enabled device wins.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_level_out[i] = pin_oe_in[i] ? pin_val_in[i] : board_level_in[i];
    end
  end
endmodule : gpc_board_model

// [tb/gpc_gpio_ctrl_test.sv]
// Self-checking bench for the general purpose control register.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); end end
module gpc_gpio_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  typedef struct {
    logic [31:0] wdata;
    logic [3:0]  strb;
    logic [7:0]  board;
    logic [7:0]  oe;
    logic [7:0]  out;
  } gpc_row_type;
  logic        clk_sys_in;
  logic        rst_in;
  logic        strap;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic        err;
  logic        role;
  logic [7:0]  board;
  logic [7:0]  pin_lvl;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  int          miscompares;
  int          n_checks;
  gpc_row_type rows [5] = '{'{32'hFFFF_FFFF, 4'hF, 8'h00, 8'hFF, 8'hFF},
                            '{32'h0000_0000, 4'hF, 8'hA5, 8'h00, 8'h00},
                            '{32'h6240_6240, 4'hF, 8'hFF, 8'hCC, 8'hAA},
                            '{32'h0000_0000, 4'hA, 8'h00, 8'h00, 8'h22},
                            '{32'hFFFF_FFFF, 4'h0, 8'h5A, 8'h00, 8'h22}};
  // ---------------------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------------------
  gpc_gpio_ctrl DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .upstream_strap_in(strap),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .gpio_pin_in(pin_lvl), .gpio_pin_out(pin_out), .gpio_pin_oe_out(pin_oe), .upstream_role_out(role));
  gpc_board_model board_i (.board_level_in(board), .pin_val_in(pin_out), .pin_oe_in(pin_oe),
    .pin_level_out(pin_lvl));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] exp_word(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] lvl);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int n = 0; n < 8; n++)
    begin
      w[4*n]   = oe[n] ? out[n] : lvl[n];
      w[4*n+1] = oe[n];
      w[4*n+2] = out[n];
    end
    return w;
  endfunction : exp_word
  // Leaves psel up so that a following call may start its setup at once.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys_in);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      miscompares++;
      end_of_test();
    end
    rdata = prdata;
    err = pslverr;
  endtask : apb
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge clk_sys_in);
  endtask : idle
  task automatic do_reset(input logic s);
    strap <= s;
    rst_in <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    `CHK({pin_oe, pin_out, role, pready}, 18'h0);
    rst_in <= 1'b0;
  endtask : do_reset
  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // ---------------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    #20000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    rst_in = 1'b1;
    strap = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    board = 8'h00;
    miscompares = 0;
    n_checks = 0;
    @(posedge clk_sys_in);
    do_reset(1'b1);
    foreach (rows[i])
    begin
      board <= rows[i].board;
      apb(1'b1, 12'hB8, rows[i].wdata, rows[i].strb);
      `CHK(err, 1'b0);
      idle(3);
      apb(1'b0, 12'hB8, 32'h0000_0000, 4'h0);
      `CHK(rdata, exp_word(rows[i].oe, rows[i].out, rows[i].board));
      `CHK(pin_oe, rows[i].oe);
      `CHK(pin_out, rows[i].out);
      `CHK(pin_lvl, (rows[i].oe & rows[i].out) | (~rows[i].oe & rows[i].board));
      idle(1);
    end
    // Low address bits are ignored, so 0xB9 reaches the same word.
    apb(1'b0, 12'hB9, 32'h0000_0000, 4'h0);
    `CHK({err, rdata}, {1'b0, exp_word(8'h00, 8'h22, 8'h5A)});
    apb(1'b1, 12'hB4, 32'hFFFF_FFFF, 4'hF);
    `CHK(err, 1'b1);
    apb(1'b0, 12'hBC, 32'h0000_0000, 4'h0);
    `CHK({err, rdata}, {1'b1, 32'h0000_0000});
    idle(2);
    `CHK(pin_oe, 8'h00);
    apb(1'b1, 12'hB8, 32'h6666_6666, 4'hF);
    idle(2);
    do_reset(1'b0);
    idle(5);
    `CHK(role, 1'b0);
    apb(1'b0, 12'hB8, 32'h0000_0000, 4'h0);
    `CHK({err, rdata}, {1'b1, 32'h0000_0000});
    apb(1'b1, 12'hB8, 32'hFFFF_FFFF, 4'hF);
    `CHK(err, 1'b1);
    idle(3);
    `CHK(pin_oe, 8'h00);
    do_reset(1'b1);
    idle(5);
    `CHK(role, 1'b1);
    apb(1'b0, 12'hB8, 32'h0000_0000, 4'h0);
    `CHK({err, rdata}, {1'b0, exp_word(8'h00, 8'h00, 8'h5A)});
    idle(1);
    end_of_test();
  end
endmodule : gpc_gpio_ctrl_test
